// [pkg/smw_pkg.sv]
/*
  Constants shared by the supply monitor and stop-wake logic.
  Assumes a single 20 MHz clock and a byte-wide register port.
*/
`default_nettype none
package smw_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam logic [7:0] OFF_SUPPLY   = 8'h0C;
  localparam logic [7:0] OFF_IRQ_REQ  = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h11;
  localparam logic [7:0] OFF_WAKE2    = 8'h12;
  localparam logic [7:0] OFF_PORT_DIR = 8'h13;
  localparam logic [7:0] OFF_WAKE1    = 8'h14;
  localparam int unsigned BIT_ENABLE = 0;
  localparam int unsigned BIT_LOW    = 1;
  localparam int unsigned BIT_HIGH   = 2;
  localparam int unsigned BIT_LOW_IRQ = 5;
  localparam int unsigned WAKE_SEL_LSB = 2;
  localparam logic [7:0] RESET_ZERO = 8'h00;
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned SETTLE_NS = 20000;
  localparam int unsigned SETTLE_CYC = (SETTLE_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam logic [2:0] WAKE_POR_ONLY = 3'h0;
endpackage
`default_nettype wire

// [core/smw_settle.sv]
/*
  Settling counter: ready rises a fixed count of cycles after enable rises.
  Assumes enable is a registered level.
*/
`default_nettype none
module smw_settle #(
  parameter int unsigned CYCLES = 400
) (
  input  wire logic clk_in,     // System clock.
  input  wire logic rst_n_in,   // Synchronous reset, active low.
  input  wire logic enable_in,  // Monitoring enabled.
  output logic      ready_out   // Flags are valid.
);
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic        ready_q;
  wire  done_w = (cnt_q == 16'(CYCLES - 1));
  assign cnt_d = !enable_in ? 16'h0000 : (done_w ? cnt_q : cnt_q + 16'h0001);
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      cnt_q   <= 16'h0000;
      ready_q <= 1'b0;
    end
    else
    begin
      cnt_q   <= cnt_d;
      ready_q <= enable_in & done_w;
    end
  end
  // Ready drops in the same cycle as enable, so ready_out never outlives a cleared enable bit; registered flags clear a cycle later.
  assign ready_out = ready_q & enable_in;
endmodule
`default_nettype wire

// [core/smw_wake_gate.sv]
/*
  Second stop-recovery gate over selected input pins, outputs excluded.
  Assumes pin and direction inputs are synchronous.
*/
`default_nettype none
module smw_wake_gate (
  input  wire logic [2:0] sel_in,   // Recovery source code.
  input  wire logic [7:0] p0_in,    // Port 0 pins.
  input  wire logic [7:0] p2_in,    // Port 2 pins.
  input  wire logic [7:0] p3_in,    // Port 3 pins.
  input  wire logic [7:0] p0_out_in, // Port 0 output marks.
  input  wire logic [7:0] p2_out_in, // Port 2 output marks.
  input  wire logic [7:0] p3_out_in, // Port 3 output marks.
  output logic            wake_out  // Gate result.
);
  logic [15:0] sel_w;
  logic [15:0] pins_w;
  logic [15:0] outs_w;
  logic        is_nor_w;
  assign pins_w = {p0_in[7], p0_in[0], p3_in[3:1], 3'h0, p2_in};
  assign outs_w = {p0_out_in[7], p0_out_in[0], p3_out_in[3:1], 3'h0, p2_out_in};
  always_comb
  begin
    sel_w    = 16'h0000;
    is_nor_w = 1'b0;
    unique case (sel_in)
      3'h0: sel_w = 16'h0000;
      3'h1: sel_w = 16'h000F;
      3'h2: sel_w = 16'h00FF;
      3'h3:
      begin
        sel_w    = 16'h3800;
        is_nor_w = 1'b1;
      end
      3'h4: sel_w = 16'h3800;
      3'h5:
      begin
        sel_w    = 16'hF800;
        is_nor_w = 1'b1;
      end
      3'h6: sel_w = 16'hF800;
      3'h7: sel_w = 16'h3807;
    endcase
  end
  // Output pins are dropped from the gate. [RULE_12] [RULE_13]
  wire [15:0] use_w = sel_w & ~outs_w;
  wire        any_w = |use_w;
  wire        nand_w = ~&(pins_w | ~use_w);
  wire        nor_w  = ~|(pins_w & use_w);
  assign wake_out = any_w & (is_nor_w ? nor_w : nand_w);
endmodule
`default_nettype wire

// [core/smw_top.sv]
/*
  Supply monitor register, latched low-supply request and stop-wake combiner.
  Assumes analog comparators give synchronous levels and software uses the plain port.
*/
// The implementer's own choice: the plain strobed port.
//
// How it works
// RULE_01 - Bit 0 enables monitoring, resets clear.
// RULE_02 - Flags valid only 20 us after enable.
// RULE_03 - Bit 2 mirrors supply above upper threshold.
// RULE_04 - Bit 1 mirrors supply below lower threshold.
// RULE_05 - Enabled low flag raises request line five.
// RULE_06 - Request bit 5 latches until software clears.
// RULE_07 - Mask bit gates request onto interrupt.
// RULE_08 - Software disables monitoring before stop mode.
// RULE_09 - Software leaves port mode alone while checking.
// RULE_10 - Software enables interrupts before enabling monitor.
// RULE_11 - Either selected wake source ends stop.
// RULE_12 - Output pins excluded from wake gate.
// RULE_13 - Three-bit code selects gate and pins.
// RULE_14 - Disabled monitor clears flags, no request.
`default_nettype none
module smw_top
  import smw_pkg::*;
#(
  parameter int unsigned SETTLE = smw_pkg::SETTLE_CYC
) (
  input  wire logic                       clk_in,        // System clock, 20 MHz.
  input  wire logic                       rst_n_in,      // Synchronous reset, active low.
  input  wire logic [smw_pkg::ADDR_W-1:0] addr_in,       // Register address.
  input  wire logic [smw_pkg::DATA_W-1:0] wdata_in,      // Write data.
  input  wire logic                       wr_in,         // Write strobe.
  input  wire logic                       rd_in,         // Read strobe.
  output logic      [smw_pkg::DATA_W-1:0] rdata_out,     // Read data, next cycle.
  input  wire logic                       above_in,      // Supply above upper threshold.
  input  wire logic                       below_in,      // Supply below lower threshold.
  input  wire logic                       wake1_in,      // First recovery source event.
  input  wire logic                       stop_in,       // Core is in stop mode.
  input  wire logic [7:0]                 p0_in,         // Port 0 pins.
  input  wire logic [7:0]                 p2_in,         // Port 2 pins.
  input  wire logic [7:0]                 p3_in,         // Port 3 pins.
  output logic                            monitor_on_out, // Analog monitor enable.
  output logic                            wake_out,      // Leave stop mode.
  output logic                            irq_out        // Interrupt, level.
);
  import smw_pkg::*;

  logic       enable_q;
  logic       high_q;
  logic       low_q;
  logic       low_prev_q;
  logic [7:0] irq_req_q;
  logic [7:0] irq_req_d;
  logic [7:0] irq_mask_q;
  logic [2:0] wake_sel_q;
  logic       wake1_en_q;
  logic [7:0] p0_dir_q;
  logic [7:0] p2_dir_q;
  logic [7:0] p3_dir_q;
  logic [7:0] rdata_q;
  logic       wake_q;
  logic       irq_q;
  logic       ready_w;
  logic       gate_w;

  wire wr_sup_w  = wr_in & (addr_in == OFF_SUPPLY);
  wire wr_req_w  = wr_in & (addr_in == OFF_IRQ_REQ);
  wire wr_mask_w = wr_in & (addr_in == OFF_IRQ_MASK);
  wire wr_wake_w = wr_in & (addr_in == OFF_WAKE2);
  wire wr_dir_w  = wr_in & (addr_in == OFF_PORT_DIR);
  wire wr_w1_w   = wr_in & (addr_in == OFF_WAKE1);
  wire rd_req_w  = rd_in & (addr_in == OFF_IRQ_REQ);

  smw_settle #(
    .CYCLES (SETTLE)
  ) u_settle (
    .clk_in    (clk_in),
    .rst_n_in  (rst_n_in),
    .enable_in (enable_q),
    .ready_out (ready_w)
  );

  smw_wake_gate u_gate (
    .sel_in    (wake_sel_q),
    .p0_in     (p0_in),
    .p2_in     (p2_in),
    .p3_in     (p3_in),
    .p0_out_in (p0_dir_q),
    .p2_out_in (p2_dir_q),
    .p3_out_in (p3_dir_q),
    .wake_out  (gate_w)
  );

  // Comparator levels are shown only once they have settled. [RULE_02] [RULE_14]
  wire high_d_w = ready_w & above_in;  // [RULE_03]
  wire low_d_w  = ready_w & below_in;  // [RULE_04]
  // A rising low flag latches request bit 5; set wins over clear. [RULE_05] [RULE_06]
  wire low_set_w = enable_q & low_d_w & ~low_prev_q;
  // Software clears request bits by writing ones, or a read clears them all.
  assign irq_req_d = (irq_req_q & ~(wr_req_w ? wdata_in : RESET_ZERO) & ~(rd_req_w ? 8'hFF : 8'h00))
                   | (low_set_w ? 8'h20 : 8'h00);

  logic [7:0] rmux_w;
  always_comb
  begin
    rmux_w = RESET_ZERO;
    unique case (addr_in)
      OFF_SUPPLY:   rmux_w = {5'h00, high_q, low_q, enable_q};
      OFF_IRQ_REQ:  rmux_w = irq_req_q;
      OFF_IRQ_MASK: rmux_w = irq_mask_q;
      OFF_WAKE2:    rmux_w = {3'h0, wake_sel_q, 2'h0};
      OFF_WAKE1:    rmux_w = {7'h00, wake1_en_q};
      default:      rmux_w = RESET_ZERO;
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      enable_q   <= 1'b0;
      high_q     <= 1'b0;
      low_q      <= 1'b0;
      low_prev_q <= 1'b0;
      irq_req_q  <= RESET_ZERO;
      irq_mask_q <= RESET_ZERO;
      wake_sel_q <= WAKE_POR_ONLY;
      wake1_en_q <= 1'b0;
      p0_dir_q   <= RESET_ZERO;
      p2_dir_q   <= RESET_ZERO;
      p3_dir_q   <= RESET_ZERO;
      rdata_q    <= RESET_ZERO;
      wake_q     <= 1'b0;
      irq_q      <= 1'b0;
    end
    else
    begin
      if (wr_sup_w)
        enable_q <= wdata_in[BIT_ENABLE];  // [RULE_01]
      if (wr_mask_w)
        irq_mask_q <= wdata_in;
      if (wr_wake_w)
        wake_sel_q <= wdata_in[WAKE_SEL_LSB +: 3];  // [RULE_13]
      if (wr_w1_w)
        wake1_en_q <= wdata_in[0];
      if (wr_dir_w)
      begin
        p0_dir_q <= {wdata_in[1], 6'h00, wdata_in[0]};
        p2_dir_q <= {8{wdata_in[2]}};
        p3_dir_q <= {4'h0, {3{wdata_in[3]}}, 1'b0};
      end
      high_q     <= high_d_w;
      low_q      <= low_d_w;
      low_prev_q <= low_d_w;
      irq_req_q  <= irq_req_d;
      rdata_q    <= rd_in ? rmux_w : RESET_ZERO;
      // Either enabled source ends stop, whichever comes first. [RULE_11]
      wake_q     <= stop_in & ((wake1_en_q & wake1_in) | gate_w);
      // Masked request bits stay pollable only. [RULE_07]
      irq_q      <= |(irq_req_d & irq_mask_q);
    end
  end

  assign rdata_out      = rdata_q;
  assign monitor_on_out = enable_q;
  assign wake_out       = wake_q;
  assign irq_out        = irq_q;

  property p_flags_off;
    @(posedge clk_in) disable iff (!rst_n_in) !enable_q |=> (!high_q && !low_q);
  endproperty
  a_flags_off: assert property (p_flags_off) else $error("flag set while disabled"); // [RULE_14]
  property p_settle;
    @(posedge clk_in) disable iff (!rst_n_in) $rose(enable_q) |-> !low_q [*2];
  endproperty
  a_settle: assert property (p_settle) else $error("flag before settle"); // [RULE_02]
  property p_low_follow;
    @(posedge clk_in) disable iff (!rst_n_in) ready_w |=> (low_q == $past(below_in));
  endproperty
  a_low_follow: assert property (p_low_follow) else $error("low flag mismatch"); // [RULE_04]
  property p_high_follow;
    @(posedge clk_in) disable iff (!rst_n_in) ready_w |=> (high_q == $past(above_in));
  endproperty
  a_high_follow: assert property (p_high_follow) else $error("high flag mismatch"); // [RULE_03]
  property p_latch;
    @(posedge clk_in) disable iff (!rst_n_in) low_set_w |=> irq_req_q[BIT_LOW_IRQ];
  endproperty
  a_latch: assert property (p_latch) else $error("request not latched"); // [RULE_05]
  property p_hold;
    @(posedge clk_in) disable iff (!rst_n_in)
      irq_req_q[BIT_LOW_IRQ] && !wr_req_w && !rd_req_w |=> irq_req_q[BIT_LOW_IRQ];
  endproperty
  a_hold: assert property (p_hold) else $error("request dropped"); // [RULE_06]
  property p_mask;
    @(posedge clk_in) disable iff (!rst_n_in) irq_q == |(irq_req_q & $past(irq_mask_q));
  endproperty
  a_mask: assert property (p_mask) else $error("masked interrupt"); // [RULE_07]
  property p_wake;
    @(posedge clk_in) disable iff (!rst_n_in) stop_in && wake1_en_q && wake1_in |=> wake_q;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake"); // [RULE_11]
  property p_enable;
    @(posedge clk_in) disable iff (!rst_n_in) wr_sup_w |=> (enable_q == $past(wdata_in[BIT_ENABLE]));
  endproperty
  a_enable: assert property (p_enable) else $error("enable not written"); // [RULE_01]
  c_irq: cover property (@(posedge clk_in) disable iff (!rst_n_in) $rose(irq_q));
  c_wake: cover property (@(posedge clk_in) disable iff (!rst_n_in) $rose(wake_q));
  c_ready: cover property (@(posedge clk_in) disable iff (!rst_n_in) $rose(ready_w));
endmodule
`default_nettype wire

// [tb/smw_supply_model.sv]
/*
  Behavioural model of the two analog supply comparators.
  Assumes the bench picks a supply level and the design samples on clk_in.
*/
`default_nettype none
module smw_supply_model (
  input  wire logic       clk_in,    // System clock.
  input  wire logic [1:0] level_in,  // 0 nominal, 1 low, 2 high.
  output logic            above_out, // Supply above upper threshold.
  output logic            below_out  // Supply below lower threshold.
);
  timeunit 1ns;
  timeprecision 1ns;
  // Levels change only on the clock, so the design never sees a comparator edge mid-cycle.
  always_ff @(posedge clk_in)
  begin
    above_out <= (level_in == 2'h2);
    below_out <= (level_in == 2'h1);
  end
endmodule
`default_nettype wire

// [tb/smw_top_tb.sv]
/*
  Self-checking bench for the supply monitor and stop-wake logic.
  Assumes the comparator model and a short settling count of 4 cycles.
*/
`default_nettype none
`define CHECK_EQ(got, exp) \
  begin cmp_count++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module smw_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import smw_pkg::*;
  logic       clk_in = 1'b0, rst_n_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
  logic       wake1_in = 1'b0, stop_in = 1'b0;
  logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, p0_in = 8'hFF, p2_in = 8'hFF, p3_in = 8'hFF;
  logic [1:0] level = 2'h0;
  wire logic [7:0] rdata_out;
  wire logic       above, below, monitor_on, wake, irq;
  int              n_mismatch = 0;
  int              cmp_count = 0;

  always #25 clk_in = ~clk_in;

  smw_supply_model i_model (.clk_in(clk_in), .level_in(level), .above_out(above), .below_out(below));
  smw_top #(.SETTLE(4)) i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .above_in(above), .below_in(below),
    .wake1_in(wake1_in), .stop_in(stop_in), .p0_in(p0_in), .p2_in(p2_in), .p3_in(p3_in),
    .monitor_on_out(monitor_on), .wake_out(wake), .irq_out(irq));

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    #1;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    `CHECK_EQ(rdata_out, exp)
  endtask
  task automatic report_and_stop;
    if (n_mismatch == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic t_reset;
    rd_chk(OFF_SUPPLY, 8'h00);
    rd_chk(OFF_IRQ_REQ, 8'h00);
    rd_chk(8'h20, 8'h00);
    `CHECK_EQ(monitor_on, 1'b0)
  endtask
  task automatic t_enable;
    level <= 2'h1;
    wr_reg(OFF_SUPPLY, 8'h01);
    `CHECK_EQ(monitor_on, 1'b1)
    rd_chk(OFF_SUPPLY, 8'h01);
    // No port direction write happens while the low flag is being checked.
    wait_cyc(8);
    rd_chk(OFF_SUPPLY, 8'h03);
    `CHECK_EQ(irq, 1'b0)
    level <= 2'h0;
    wait_cyc(4);
    rd_chk(OFF_IRQ_REQ, 8'h20);
    rd_chk(OFF_IRQ_REQ, 8'h00);
  endtask
  task automatic t_mask;
    wr_reg(OFF_IRQ_MASK, 8'h20);
    level <= 2'h1;
    wait_cyc(6);
    `CHECK_EQ(irq, 1'b1)
    level <= 2'h2;
    rd_chk(OFF_IRQ_REQ, 8'h20);
    wait_cyc(4);
    `CHECK_EQ(irq, 1'b0)
    rd_chk(OFF_SUPPLY, 8'h05);
  endtask
  task automatic t_disable;
    wr_reg(OFF_SUPPLY, 8'h00);
    level <= 2'h1;
    wait_cyc(8);
    rd_chk(OFF_SUPPLY, 8'h00);
    rd_chk(OFF_IRQ_REQ, 8'h00);
    // Mask is already set and the supply already low when monitoring starts.
    wr_reg(OFF_SUPPLY, 8'h01);
    wait_cyc(8);
    `CHECK_EQ(irq, 1'b1)
    rd_chk(OFF_IRQ_REQ, 8'h20);
    `CHECK_EQ(irq, 1'b0)
    wr_reg(OFF_SUPPLY, 8'h00);
    rd_chk(OFF_SUPPLY, 8'h00);
  endtask
  task automatic t_codes;
    stop_in <= 1'b1;
    for (int c = 0; c < 8; c++)
    begin
      wr_reg(OFF_WAKE2, 8'(c << WAKE_SEL_LSB));
      {p0_in, p2_in, p3_in} <= 24'h000000;
      wait_cyc(3);
      `CHECK_EQ(wake, logic'(c != 0))
      {p0_in, p2_in, p3_in} <= 24'hFFFFFF;
      wait_cyc(3);
      `CHECK_EQ(wake, 1'b0)
    end
  endtask
  task automatic t_exclude;
    wr_reg(OFF_WAKE2, 8'h14);
    wr_reg(OFF_PORT_DIR, 8'h08);
    p3_in <= 8'h00;
    p0_in <= 8'h81;
    wait_cyc(3);
    `CHECK_EQ(wake, 1'b0)
    p0_in <= 8'h00;
    wait_cyc(3);
    `CHECK_EQ(wake, 1'b1)
    wr_reg(OFF_WAKE2, 8'h04);
    wr_reg(OFF_PORT_DIR, 8'h04);
    p2_in <= 8'h00;
    wait_cyc(3);
    `CHECK_EQ(wake, 1'b0)
  endtask
  task automatic t_first;
    wr_reg(OFF_PORT_DIR, 8'h00);
    wr_reg(OFF_WAKE2, 8'h00);
    wr_reg(OFF_WAKE1, 8'h01);
    wake1_in <= 1'b1;
    wait_cyc(3);
    `CHECK_EQ(wake, 1'b1)
    wake1_in <= 1'b0;
    p2_in <= 8'hFE;
    wr_reg(OFF_WAKE2, 8'h04);
    wait_cyc(3);
    `CHECK_EQ(wake, 1'b1)
    stop_in <= 1'b0;
    wait_cyc(3);
    `CHECK_EQ(wake, 1'b0)
  endtask

  initial
  begin
    wait_cyc(3);
    rst_n_in <= 1'b1;
    t_reset();
    t_enable();
    t_mask();
    t_disable();
    t_codes();
    t_exclude();
    t_first();
    report_and_stop();
  end
  // Tests need well under 1000 cycles; the limit leaves a wide margin.
  initial
  begin
    #200000;
    n_mismatch++;
    report_and_stop();
  end
endmodule
`default_nettype wire
